/* File: rtl/adcsp_pkg.sv */
// package of constants and carrier types for the serial conversion port
package adcsp_pkg;

  // ==========================================================================
  // frame geometry
  localparam int unsigned ADCSP_FRAME_EDGES   = 16;
  localparam int unsigned ADCSP_TRACK_EDGES   = 3;
  localparam int unsigned ADCSP_HOLD_EDGE     = 4;
  localparam int unsigned ADCSP_ZERO_BITS     = 4;
  localparam int unsigned ADCSP_RESULT_BITS   = 12;
  localparam int unsigned ADCSP_CTRL_BITS     = 8;
  localparam int unsigned ADCSP_CHAN_HI       = 5;
  localparam int unsigned ADCSP_CHAN_LO       = 3;

  localparam logic [4:0]  ADCSP_EDGE_ZERO     = 5'h00;
  localparam logic [4:0]  ADCSP_EDGE_HOLD     = 5'h04;
  localparam logic [4:0]  ADCSP_EDGE_LAST     = 5'h10;
  localparam logic [3:0]  ADCSP_RISE_CTRL_END = 4'h8;
  localparam logic [7:0]  ADCSP_CTRL_RESET    = 8'h00;
  localparam logic [2:0]  ADCSP_CHAN_GND      = 3'h7;
  localparam logic [11:0] ADCSP_RESULT_ZERO   = 12'h000;

  // ==========================================================================
  // conversion phases, one-hot
  typedef enum logic [3:0] {
    ADCSP_IDLE  = 4'b0001,
    ADCSP_TRACK = 4'b0010,
    ADCSP_CONV  = 4'b0100,
    ADCSP_DOWN  = 4'b1000
  } adcsp_phase_t;

  // synchronised pin levels and edges
  typedef struct packed {
    logic cs_low;
    logic sclk_fall;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;
    logic din;
  } adcsp_pins_t;

  // converter core request: hold pulse and channel
  typedef struct packed {
    logic       sample;
    logic [2:0] chan;
  } adcsp_sample_t;

endpackage : adcsp_pkg

/* File: rtl/adcsp_pin_sync.sv */
// pin synchroniser and edge detector for the serial port pins
`timescale 1ns/1ps
module adcsp_pin_sync
  import adcsp_pkg::*;
(
  // clock and reset
  input  wire logic  clock_in,
  input  wire logic  rst_b_in,
  // raw pins
  input  wire logic  cs_b_in,
  input  wire logic  sclk_in,
  input  wire logic  din_in,
  // synchronised view
  output adcsp_pins_t pins_out
);

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic       sclk_d;
    logic       cs_b_d;
    adcsp_pins_t pins;
  } adcsp_sync_t;

  adcsp_sync_t st;
  adcsp_sync_t next_st;

  // ==========================================================================
  // next state: second stage feeds edge logic, first stage feeds only second
  always_comb begin
    next_st              = st;
    next_st.meta         = {cs_b_in, sclk_in, din_in};
    next_st.sync         = st.meta;
    next_st.cs_b_d       = st.sync[2];
    next_st.sclk_d       = st.sync[1];
    next_st.pins.cs_low  = ~st.sync[2];
    next_st.pins.din     = st.sync[0];
    next_st.pins.cs_fall = st.cs_b_d & ~st.sync[2];
    next_st.pins.cs_rise = ~st.cs_b_d & st.sync[2];
    next_st.pins.sclk_fall = st.sclk_d & ~st.sync[1];
    next_st.pins.sclk_rise = ~st.sclk_d & st.sync[1];
  end

  // state register, idle pins are high
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '{meta: 3'h7, sync: 3'h7, sclk_d: 1'b1, cs_b_d: 1'b1, pins: '0};
    end else begin
      st <= next_st;
    end
  end

  assign pins_out = st.pins;

endmodule : adcsp_pin_sync

/* File: rtl/adcsp_port.sv */
// serial framing and conversion sequencer of the seven-channel converter
// Function
// RULE1: conversion starts at chip select low and lasts 16 serial clock cycles
// RULE2: back-to-back conversions continue while chip select stays low
// RULE3: control word loaded now selects channel of the next conversion
// RULE4: chip select falling enables serial output driver
// RULE5: first internal falling edge enters track for three cycles
// RULE6: fourth falling edge switches to hold and captures the sample
// RULE7: internal clock gated off while chip select is high
// RULE8: clock low at chip select rise gives synthetic first falling edge
// RULE9: clock high at rise means first real falling edge starts tracking
// RULE10: output is four zeros then twelve result bits MSB first
// RULE11: bits change on falling edges, result lsb on 16th falling edge
// RULE12: host samples leading zeros only if first edge is falling
// RULE13: first 8 rising edges shift control word MSB first, rest ignored
// RULE14: host supplies a valid control word every conversion
// RULE15: control register is zero after power-up, first channel
// RULE16: bits 5..3 pick channel, codes 0..6 inputs, 7 ground
// RULE17: control bits 7, 6, 2, 1, 0 have no effect
// RULE18: powered while selected, powered down between 16th and next first edge
// RULE19: chip select rise tri-states output and abandons partial work
`timescale 1ns/1ps
module adcsp_port
  import adcsp_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  // host serial pins
  input  wire logic        cs_b_in,
  input  wire logic        sclk_in,
  input  wire logic        din_in,
  output logic             dout_out,
  output logic             dout_oe_out,
  // converter core side
  input  wire logic [11:0] core_result_in,
  output logic             core_track_out,
  output logic             core_sample_out,
  output logic [2:0]       core_chan_out,
  output logic             core_power_out
);

  // ==========================================================================
  // state
  typedef struct packed {
    adcsp_phase_t  phase;
    logic [4:0]    falls;
    logic [3:0]    rises;
    logic          sclk_low_at_rise;
    logic [7:0]    ctrl_shift;
    logic [7:0]    ctrl;
    logic [11:0]   result_shift;
    logic          dout;
    logic          dout_oe;
    logic          track;
    logic          power;
    adcsp_sample_t smp;
    logic          sclk_lvl;
  } adcsp_state_t;

  adcsp_state_t st;
  adcsp_state_t next_st;
  adcsp_pins_t  pins;
  logic         int_fall;

  // ==========================================================================
  // pin synchroniser
  adcsp_pin_sync u_sync (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .cs_b_in  (cs_b_in),
    .sclk_in  (sclk_in),
    .din_in   (din_in),
    .pins_out (pins)
  );

  // internal falling edge, gated by chip select, synthetic on select fall
  always_comb begin
    int_fall = pins.cs_low & pins.sclk_fall;                          // [RULE7]
    if (pins.cs_fall && st.sclk_low_at_rise) begin
      int_fall = 1'b1;                                                // [RULE8]
    end
  end

  // ==========================================================================
  // sequencer
  always_comb begin
    next_st          = st;
    next_st.smp.sample = 1'b0;
    // track the level of the clock pin from pin edges
    if (pins.sclk_fall) begin
      next_st.sclk_lvl = 1'b0;
    end else if (pins.sclk_rise) begin
      next_st.sclk_lvl = 1'b1;
    end
    if (pins.cs_rise) begin
      // deselect: abandon frame, float output
      next_st.phase       = ADCSP_IDLE;                               // [RULE19]
      next_st.falls       = ADCSP_EDGE_ZERO;
      next_st.rises       = '0;
      next_st.ctrl_shift  = ADCSP_CTRL_RESET;
      next_st.dout_oe     = 1'b0;
      next_st.dout        = 1'b0;
      next_st.track       = 1'b0;
      next_st.power       = 1'b0;                                     // [RULE18]
      next_st.sclk_low_at_rise = ~st.sclk_lvl;                        // [RULE8] [RULE9]
    end else if (pins.cs_low) begin
      if (pins.cs_fall) begin
        // frame start: drive output, first leading zero
        next_st.dout_oe = 1'b1;                                       // [RULE4]
        next_st.dout    = 1'b0;
        next_st.power   = 1'b1;
        next_st.falls   = ADCSP_EDGE_ZERO;                            // [RULE1]
        next_st.rises   = '0;
        next_st.phase   = ADCSP_DOWN;
      end
      if (int_fall) begin
        if (st.falls == ADCSP_EDGE_LAST || st.phase != ADCSP_CONV && st.phase != ADCSP_TRACK
            || pins.cs_fall) begin
          // first falling edge of a conversion
          next_st.falls  = 5'h01;
          next_st.rises  = '0;
          next_st.phase  = ADCSP_TRACK;                               // [RULE5] [RULE2]
          next_st.track  = 1'b1;
          next_st.power  = 1'b1;
          next_st.dout   = 1'b0;                                      // [RULE10]
        end else begin
          next_st.falls = st.falls + 5'h01;
          if (st.falls + 5'h01 == ADCSP_EDGE_HOLD) begin
            // hold: capture with channel of the previous control word
            next_st.phase        = ADCSP_CONV;                        // [RULE6]
            next_st.track        = 1'b0;
            next_st.smp.sample   = 1'b1;
            next_st.result_shift = core_result_in;
            next_st.dout         = 1'b0;                              // [RULE10]
          end else if (st.falls + 5'h01 > ADCSP_EDGE_HOLD) begin
            // result bits MSB first, lsb on the 16th edge
            next_st.dout         = st.result_shift[ADCSP_RESULT_BITS-1];   // [RULE11]
            next_st.result_shift = {st.result_shift[10:0], 1'b0};
            if (st.falls + 5'h01 == ADCSP_EDGE_LAST) begin
              next_st.power = 1'b0;                                   // [RULE18]
              next_st.phase = ADCSP_DOWN;
            end
          end else begin
            next_st.dout = 1'b0;                                      // [RULE10]
          end
        end
      end
      // control word on first eight rising edges of the conversion
      if (pins.sclk_rise && !pins.cs_fall && st.phase != ADCSP_IDLE) begin
        if (st.rises < ADCSP_RISE_CTRL_END) begin
          next_st.ctrl_shift = {st.ctrl_shift[6:0], pins.din};        // [RULE13]
          next_st.rises      = st.rises + 4'h1;
          if (st.rises + 4'h1 == ADCSP_RISE_CTRL_END) begin
            next_st.ctrl = {st.ctrl_shift[6:0], pins.din};            // [RULE3]
          end
        end
      end
    end
    // channel moves only at the hold edge, from bits 5..3 of the last full word
    if (next_st.smp.sample) begin
      next_st.smp.chan = st.ctrl[ADCSP_CHAN_HI:ADCSP_CHAN_LO];        // [RULE3] [RULE16] [RULE17]
    end
  end

  // state register; control word zero at power-up
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '{phase: ADCSP_IDLE, falls: ADCSP_EDGE_ZERO, rises: 4'h0,
              sclk_low_at_rise: 1'b0, ctrl_shift: ADCSP_CTRL_RESET,
              ctrl: ADCSP_CTRL_RESET, result_shift: ADCSP_RESULT_ZERO,   // [RULE15]
              dout: 1'b0, dout_oe: 1'b0, track: 1'b0, power: 1'b0,
              smp: '0, sclk_lvl: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign dout_out        = st.dout;
  assign dout_oe_out     = st.dout_oe;
  assign core_track_out  = st.track;
  assign core_sample_out = st.smp.sample;
  assign core_chan_out   = st.smp.chan;
  assign core_power_out  = st.power;

endmodule : adcsp_port

/* File: test/adcsp_port_sva.sv */
// concurrent checks on the serial conversion port outputs
`timescale 1ns/1ps
module adcsp_port_sva (
  // clock and reset
  input wire logic       clock_in,
  input wire logic       rst_b_in,
  // watched ports
  input wire logic       cs_b_in,
  input wire logic       dout_out,
  input wire logic       dout_oe_out,
  input wire logic       core_track_out,
  input wire logic       core_sample_out,
  input wire logic [2:0] core_chan_out,
  input wire logic       core_power_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // ==========================================================================
  // chip select settled past the pin sync delay
  sequence cs_idle;
    cs_b_in [*6];
  endsequence
  sequence cs_sel;
    !cs_b_in [*6];
  endsequence
  // ==========================================================================
  // output pin, power and hold relations
  oe_idle_off_a: assert property (cs_idle |-> !dout_oe_out) else $error("dout driven while idle");
  oe_sel_on_a: assert property (cs_sel |-> dout_oe_out) else $error("dout released while selected");
  power_idle_a: assert property (cs_idle |-> !core_power_out && !core_track_out) else $error("awake idle");
  sample_pulse_a: assert property (core_sample_out |=> !core_sample_out) else $error("hold pulse too long");
  hold_end_a: assert property (core_sample_out |-> !core_track_out && $past(core_track_out)) else $error("no track");
  track_zero_a: assert property (core_track_out |-> !dout_out && core_power_out) else $error("bad lead bit");
  chan_hold_a: assert property ($changed(core_chan_out) |-> core_sample_out) else $error("channel moved off hold");
  sample_pwr_a: assert property (core_sample_out |-> core_power_out) else $error("sample while powered down");
endmodule : adcsp_port_sva
bind adcsp_port adcsp_port_sva u_sva (.clock_in(clock_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b_in),
  .dout_out(dout_out), .dout_oe_out(dout_oe_out), .core_track_out(core_track_out),
  .core_sample_out(core_sample_out), .core_chan_out(core_chan_out), .core_power_out(core_power_out));

/* File: test/adcsp_host.sv */
// host serial controller model driving the conversion port pins
`timescale 1ns/1ps
module adcsp_host (
  // clock and serial pins
  input  wire logic clock_in,
  input  wire logic dout_in,
  output logic      cs_b_out,
  output logic      sclk_out,
  output logic      din_out
);
  localparam int HALF = 6; // sclk half period in clocks
  // idle pins at time zero
  initial begin
    cs_b_out = 1'b1;
    sclk_out = 1'b1;
    din_out  = 1'b0;
  end
  // ==========================================================================
  // chip select change, then settle
  task automatic cs_set(input logic lvl);
    @(posedge clock_in);
    cs_b_out <= lvl;
    repeat (HALF) @(posedge clock_in);
  endtask : cs_set
  // n sclk cycles: fall and din change, then rise and dout sample
  task automatic conv(input logic [7:0] c, input int n, output logic [15:0] w);
    w = 16'h0000;
    for (int i = 0; i < n; i++) begin
      @(posedge clock_in);
      sclk_out <= 1'b0;
      din_out  <= (i < 8) ? c[7 - i] : ~c[15 - i];
      repeat (HALF) @(posedge clock_in);
      sclk_out <= 1'b1;
      w[15 - i] = dout_in;
      repeat (HALF - 1) @(posedge clock_in);
    end
  endtask : conv
endmodule : adcsp_host

/* File: test/adcsp_port_tb.sv */
// self-checking bench for the serial conversion port
`timescale 1ns/1ps
module adcsp_port_tb;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [11:0] res;
    logic [2:0]  chan;
  } adcsp_row_t;
  // control word with noise in ignored bits, result, channel due at this hold
  adcsp_row_t  rows [8] = '{'{8'h08, 12'hFFF, 3'h0}, '{8'hD2, 12'h800, 3'h1}, '{8'h1F, 12'h001, 3'h2},
    '{8'hE0, 12'hA5C, 3'h3}, '{8'h2D, 12'h3C3, 3'h4}, '{8'h33, 12'h7FE, 3'h5}, '{8'hF8, 12'h000, 3'h6},
    '{8'h47, 12'h5A5, 3'h7}};
  logic        clock_in    = 1'b0;
  logic        rst_b_in    = 1'b0;
  logic [11:0] core_result = 12'h000;
  logic        cs_b, sclk, din, dout, dout_oe, track, sample, power;
  logic [2:0]  chan;
  logic [2:0]  seen_chan   = 3'h0;
  logic [15:0] word;
  int          fails       = 0;
  int          check_count = 0;
  int          samples     = 0;
  always #10 clock_in = ~clock_in;
  adcsp_host host (.clock_in(clock_in), .dout_in(dout), .cs_b_out(cs_b), .sclk_out(sclk), .din_out(din));
  adcsp_port dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b), .sclk_in(sclk), .din_in(din),
    .dout_out(dout), .dout_oe_out(dout_oe), .core_result_in(core_result), .core_track_out(track),
    .core_sample_out(sample), .core_chan_out(chan), .core_power_out(power));
  // channel and count of hold pulses
  always @(posedge clock_in) begin
    if (sample === 1'b1) begin
      seen_chan <= chan;
      samples   <= samples + 1;
    end
  end
  // ==========================================================================
  // compare and verdict
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // one whole conversion and its checks
  task automatic run(input logic [7:0] c, input logic [11:0] r, input logic [2:0] ch);
    core_result <= r;
    samples = 0;
    host.conv(c, 16, word);
    chk("word", word, {4'h0, r});
    chk("chan", {13'h0, seen_chan}, {13'h0, ch});
    chk("holds", samples[15:0], 16'h0001);
  endtask : run
  // ==========================================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clock_in);
    rst_b_in <= 1'b1;
    chk("reset", {12'h0, dout_oe, power, track, sample}, 16'h0000);
    repeat (3) @(posedge clock_in);
    host.cs_set(1'b0);
    chk("oe_on", {15'h0, dout_oe}, 16'h0001);
    foreach (rows[i]) begin
      run(rows[i].ctrl, rows[i].res, rows[i].chan);
    end
    host.cs_set(1'b1);
    chk("oe_off", {15'h0, dout_oe}, 16'h0000);
    // frame ending in an aborted load with sclk low
    host.cs_set(1'b0);
    run(8'h38, 12'h6B1, 3'h0);
    host.conv(8'h10, 5, word);
    @(posedge clock_in);
    host.sclk_out <= 1'b0;
    host.cs_set(1'b1);
    chk("abort_oe", {15'h0, dout_oe}, 16'h0000);
    // chip select fall gives the first falling edge
    host.cs_set(1'b0);
    run(8'h00, 12'h9E7, 3'h7);
    host.cs_set(1'b1);
    print_verdict();
  end
  // hang cut-off
  initial begin
    repeat (20000) @(posedge clock_in);
    fails++;
    print_verdict();
  end
endmodule : adcsp_port_tb
